// ===== rtl/event_status_flags.sv
// Purpose: read-clear event flag register and active-low interrupt pin
// Assumes: event inputs are one-cycle pulses on clk, except tamper_pin
// Notes: a read returns the flags and clears them in the same cycle
//
// Overview of operation
// - register is read-only, cleared by reading it
// - bit 15 set on measurement timeout
// - bit 14 set when clock alarm matches
// - bit 12 set when flight command finishes
// - per-cycle flight events set bit 12 when enabled
// - bit 11 set when temperature command finishes
// - per-cycle thermal events set bit 11 when enabled
// - bit 10 set when commanded regulator stabilises
// - bit 9 set after last auto flight cycle
// - bit 8 set after last auto thermal measurement
// - bit 7 set when flash becomes ready
// - serial port idle during flash writing commands
// - flash write completion raises interrupt if enabled
// - bit 6 set after manual calibrate finishes
// - automatic calibrations never set bit 6
// - bit 5 set when halt command finishes
// - bit 4 set on high tamper pin
// - bit 3 set when initialise command finishes
// - bit 2 set at power-up; port idle before
// - interrupt pin held until register is read
`timescale 1ns/1ns
`include "event_status_flags_consts.svh"

module event_status_flags (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic status_rd,
    output logic [`ESF_WIDTH-1:0] status_rdata,
    output logic status_rvalid,
    input wire logic [`ESF_WIDTH-1:0] irq_source_en,
    output logic int_n,
    output logic spi_active,
    input wire logic supply_good,
    input wire logic timeout_evt,
    input wire logic alarm_match_evt,
    input wire logic flight_cmd_done,
    input wire logic thermal_cmd_done,
    input wire event_status_flags_pkg::seq_mode_t seq_mode,
    input wire logic per_cycle_irq,
    input wire logic flight_cycle_done,
    input wire logic thermal_cycle_done,
    input wire logic flight_last_done,
    input wire logic thermal_last_done,
    input wire logic regulator_timed_cmd,
    input wire logic regulator_on_cmd,
    input wire logic regulator_stable,
    input wire logic flash_ready_evt,
    input wire logic flash_write_busy,
    input wire logic trim_done,
    input wire logic trim_auto,
    input wire logic stop_done,
    input wire logic tamper_pin,
    input wire logic tamper_rearm,
    input wire logic setup_done
);

    event_status_flags_pkg::flag_word_t flags;
    event_status_flags_pkg::flag_word_t next_flags;
    event_status_flags_pkg::power_state_t power_state;

    logic window_expired;
    logic clock_alarm_hit;
    logic flight_time_done;
    logic thermal_meas_done;
    logic regulator_ready;
    logic auto_flight_done;
    logic auto_thermal_done;
    logic nvm_ready;
    logic trim_run_done;
    logic stop_cmd_done;
    logic tamper_flag;
    logic setup_cmd_done;
    logic power_up_flag;

    logic rd_take;
    logic seq_has_flight;
    logic seq_has_thermal;
    logic regulator_stable_q;
    logic regulator_rise;
    logic flash_busy_q;
    logic flash_write_end;
    logic tamper_level;
    logic tamper_armed;
    logic tamper_hit;
    logic power_announce;

    // set has priority so an event in the read cycle is never lost
    function automatic logic next_flag(input logic cur, input logic set,
                                       input logic clr);
        return set | (cur & ~clr);
    endfunction : next_flag

    function automatic logic any_enabled(
        input event_status_flags_pkg::flag_word_t word,
        input event_status_flags_pkg::flag_word_t en);
        return |(word & en);
    endfunction : any_enabled

    pin_level_sync tamper_sync (
        .clk(clk),
        .rst_n(rst_n),
        .pin(tamper_pin),
        .level(tamper_level)
    );

    // reads are only taken while the serial port is live
    assign rd_take = status_rd & spi_active;
    assign seq_has_flight = (seq_mode == event_status_flags_pkg::SEQ_BOTH)
        || (seq_mode == event_status_flags_pkg::SEQ_FLIGHT);
    assign seq_has_thermal = (seq_mode == event_status_flags_pkg::SEQ_BOTH)
        || (seq_mode == event_status_flags_pkg::SEQ_THERMAL);
    assign regulator_rise = regulator_stable & ~regulator_stable_q
        & (regulator_timed_cmd | regulator_on_cmd);
    assign flash_write_end = flash_busy_q & ~flash_write_busy;
    assign tamper_hit = tamper_level & tamper_armed;
    assign power_announce =
        (power_state == event_status_flags_pkg::PWR_ANNOUNCE);

    // power-up sequencing; port stays idle until the flag is posted
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            power_state <= event_status_flags_pkg::PWR_WAIT;
        end else begin
            case (power_state)
                event_status_flags_pkg::PWR_WAIT: begin
                    if (supply_good) begin
                        power_state <= event_status_flags_pkg::PWR_ANNOUNCE;
                    end
                end
                event_status_flags_pkg::PWR_ANNOUNCE: begin
                    power_state <= event_status_flags_pkg::PWR_READY;
                end
                event_status_flags_pkg::PWR_READY: begin
                    power_state <= event_status_flags_pkg::PWR_READY;
                end
                default: begin
                    power_state <= event_status_flags_pkg::PWR_WAIT;
                end
            endcase
        end
    end

    // flash writing commands also silence the port
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            spi_active <= 1'b0;
        end else begin
            spi_active <= (power_state == event_status_flags_pkg::PWR_READY)
                & ~flash_write_busy;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            regulator_stable_q <= 1'b0;
            flash_busy_q <= 1'b0;
        end else begin
            regulator_stable_q <= regulator_stable;
            flash_busy_q <= flash_write_busy;
        end
    end

    // one tamper event per arming; a steady high pin does not refire
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tamper_armed <= 1'b1;
        end else if (tamper_rearm) begin
            tamper_armed <= 1'b1;
        end else if (tamper_hit) begin
            tamper_armed <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            window_expired <= 1'b0;
        end else begin
            window_expired <= next_flag(window_expired, timeout_evt,
                                        rd_take);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            clock_alarm_hit <= 1'b0;
        end else begin
            clock_alarm_hit <= next_flag(clock_alarm_hit, alarm_match_evt,
                                         rd_take);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flight_time_done <= 1'b0;
        end else begin
            flight_time_done <= next_flag(flight_time_done,
                flight_cmd_done
                | (flight_cycle_done & seq_has_flight & per_cycle_irq),
                rd_take);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            thermal_meas_done <= 1'b0;
        end else begin
            thermal_meas_done <= next_flag(thermal_meas_done,
                thermal_cmd_done
                | (thermal_cycle_done & seq_has_thermal
                & per_cycle_irq),
                rd_take);
        end
    end

    // flash commands are the host's to hold off until this is seen
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            regulator_ready <= 1'b0;
        end else begin
            regulator_ready <= next_flag(regulator_ready, regulator_rise,
                                         rd_take);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            auto_flight_done <= 1'b0;
        end else begin
            auto_flight_done <= next_flag(auto_flight_done,
                flight_last_done & seq_has_flight, rd_take);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            auto_thermal_done <= 1'b0;
        end else begin
            auto_thermal_done <= next_flag(auto_thermal_done,
                thermal_last_done & seq_has_thermal, rd_take);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            nvm_ready <= 1'b0;
        end else begin
            nvm_ready <= next_flag(nvm_ready,
                flash_ready_evt | flash_write_end, rd_take);
        end
    end

    // calibrations launched by the sequencer stay silent
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            trim_run_done <= 1'b0;
        end else begin
            trim_run_done <= next_flag(trim_run_done,
                trim_done & ~trim_auto, rd_take);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stop_cmd_done <= 1'b0;
        end else begin
            stop_cmd_done <= next_flag(stop_cmd_done, stop_done,
                                       rd_take);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tamper_flag <= 1'b0;
        end else begin
            tamper_flag <= next_flag(tamper_flag, tamper_hit,
                                     rd_take);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            setup_cmd_done <= 1'b0;
        end else begin
            setup_cmd_done <= next_flag(setup_cmd_done, setup_done,
                                        rd_take);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            power_up_flag <= 1'b0;
        end else begin
            power_up_flag <= next_flag(power_up_flag, power_announce,
                                       rd_take);
        end
    end

    always_comb begin
        flags = `ESF_RESET;
        flags[`ESF_BIT_WINDOW_EXPIRED] = window_expired;
        flags[`ESF_BIT_CLOCK_ALARM_HIT] = clock_alarm_hit;
        flags[`ESF_BIT_FLIGHT_TIME_DONE] = flight_time_done;
        flags[`ESF_BIT_THERMAL_MEAS_DONE] = thermal_meas_done;
        flags[`ESF_BIT_REGULATOR_READY] = regulator_ready;
        flags[`ESF_BIT_AUTO_FLIGHT_DONE] = auto_flight_done;
        flags[`ESF_BIT_AUTO_THERMAL_DONE] = auto_thermal_done;
        flags[`ESF_BIT_NVM_READY] = nvm_ready;
        flags[`ESF_BIT_TRIM_RUN_DONE] = trim_run_done;
        flags[`ESF_BIT_STOP_CMD_DONE] = stop_cmd_done;
        flags[`ESF_BIT_TAMPER_FLAG] = tamper_flag;
        flags[`ESF_BIT_SETUP_CMD_DONE] = setup_cmd_done;
        flags[`ESF_BIT_POWER_UP_FLAG] = power_up_flag;
        flags = flags & ~`ESF_RESERVED_MASK;
    end

    // value the flags take at the next edge, for the interrupt pin
    always_comb begin
        next_flags = `ESF_RESET;
        next_flags[`ESF_BIT_WINDOW_EXPIRED] = timeout_evt;
        next_flags[`ESF_BIT_CLOCK_ALARM_HIT] = alarm_match_evt;
        next_flags[`ESF_BIT_FLIGHT_TIME_DONE] = flight_cmd_done
            | (flight_cycle_done & seq_has_flight & per_cycle_irq);
        next_flags[`ESF_BIT_THERMAL_MEAS_DONE] = thermal_cmd_done
            | (thermal_cycle_done & seq_has_thermal & per_cycle_irq);
        next_flags[`ESF_BIT_REGULATOR_READY] = regulator_rise;
        next_flags[`ESF_BIT_AUTO_FLIGHT_DONE] =
            flight_last_done & seq_has_flight;
        next_flags[`ESF_BIT_AUTO_THERMAL_DONE] =
            thermal_last_done & seq_has_thermal;
        next_flags[`ESF_BIT_NVM_READY] = flash_ready_evt | flash_write_end;
        next_flags[`ESF_BIT_TRIM_RUN_DONE] = trim_done & ~trim_auto;
        next_flags[`ESF_BIT_STOP_CMD_DONE] = stop_done;
        next_flags[`ESF_BIT_TAMPER_FLAG] = tamper_hit;
        next_flags[`ESF_BIT_SETUP_CMD_DONE] = setup_done;
        next_flags[`ESF_BIT_POWER_UP_FLAG] = power_announce;
        if (!rd_take) begin
            next_flags = next_flags | flags;
        end
        next_flags = next_flags & ~`ESF_RESERVED_MASK;
    end

    // pin tracks enabled pending flags, so it holds until a read
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            int_n <= 1'b1;
        end else begin
            int_n <= ~any_enabled(next_flags, irq_source_en);
        end
    end

    // read snapshot goes out while the live flags clear together
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            status_rdata <= `ESF_RESET;
            status_rvalid <= 1'b0;
        end else begin
            status_rvalid <= rd_take;
            if (rd_take) begin
                status_rdata <= flags;
            end
        end
    end

endmodule : event_status_flags

// ===== include/event_status_flags_consts.svh
// Purpose: bit positions, reset values and counts of the event flag register
// Assumes: included by bare name from the package and the design files
// Notes: definitions only
`ifndef EVENT_STATUS_FLAGS_CONSTS_SVH
`define EVENT_STATUS_FLAGS_CONSTS_SVH

`define ESF_WIDTH 16
`define ESF_RESET 16'h0000
`define ESF_SYNC_STAGES 3

`define ESF_BIT_WINDOW_EXPIRED 15
`define ESF_BIT_CLOCK_ALARM_HIT 14
`define ESF_BIT_RESERVED_13 13
`define ESF_BIT_FLIGHT_TIME_DONE 12
`define ESF_BIT_THERMAL_MEAS_DONE 11
`define ESF_BIT_REGULATOR_READY 10
`define ESF_BIT_AUTO_FLIGHT_DONE 9
`define ESF_BIT_AUTO_THERMAL_DONE 8
`define ESF_BIT_NVM_READY 7
`define ESF_BIT_TRIM_RUN_DONE 6
`define ESF_BIT_STOP_CMD_DONE 5
`define ESF_BIT_TAMPER_FLAG 4
`define ESF_BIT_SETUP_CMD_DONE 3
`define ESF_BIT_POWER_UP_FLAG 2
`define ESF_BIT_RESERVED_1 1
`define ESF_BIT_RESERVED_0 0

`define ESF_RESERVED_MASK 16'h2003

`endif

// ===== include/event_status_flags_pkg.sv
// Purpose: types shared by the event flag register and its bench
// Assumes: constants come from the consts header
// Notes: no constants live here, only types
`include "event_status_flags_consts.svh"

package event_status_flags_pkg;

    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_BOTH = 2'b01,
        SEQ_FLIGHT = 2'b10,
        SEQ_THERMAL = 2'b11
    } seq_mode_t;

    typedef enum logic [1:0] {
        PWR_WAIT = 2'b00,
        PWR_ANNOUNCE = 2'b01,
        PWR_READY = 2'b10
    } power_state_t;

    typedef logic [`ESF_WIDTH-1:0] flag_word_t;

endpackage : event_status_flags_pkg

// ===== rtl/pin_level_sync.sv
// Purpose: bring an outside pin level into the core clock domain
// Assumes: single core clock, asynchronous active-low reset
// Notes: output moves only once the second and third stages agree
`timescale 1ns/1ns
`include "event_status_flags_consts.svh"

module pin_level_sync (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic pin,
    output logic level
);

    logic [`ESF_SYNC_STAGES-1:0] stage;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stage <= '0;
        end else begin
            stage <= {stage[`ESF_SYNC_STAGES-2:0], pin};
        end
    end

    // stage[0] feeds stage[1] only; agreement filters a late-settling edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            level <= 1'b0;
        end else if (stage[1] == stage[2]) begin
            level <= stage[2];
        end
    end

endmodule : pin_level_sync

// ===== bench/event_status_flags_asserts.sv
// Purpose: port timing checks for the event flag register
// Assumes: one clock, asynchronous active-low reset
// Notes: flags are seen only through int_n and read answers
`timescale 1ns/1ns
`include "event_status_flags_consts.svh"
module event_status_flags_asserts (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic status_rd,
    input wire logic [`ESF_WIDTH-1:0] status_rdata,
    input wire logic status_rvalid,
    input wire logic [`ESF_WIDTH-1:0] irq_source_en,
    input wire logic int_n,
    input wire logic spi_active,
    input wire event_status_flags_pkg::seq_mode_t seq_mode,
    input wire logic per_cycle_irq,
    input wire logic flight_cycle_done,
    input wire logic flash_write_busy,
    input wire logic trim_done,
    input wire logic trim_auto,
    input wire logic stop_done
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_read_answers: assert property (
        status_rd && spi_active |=> status_rvalid) else $error("no answer");
    a_refused_read: assert property (
        !(status_rd && spi_active) |=> !status_rvalid)
        else $error("answer without taken read");
    a_reserved_zero: assert property (
        status_rvalid |-> (status_rdata & 16'h2003) == 16'h0000)
        else $error("reserved bits set");
    a_halt_raises_int: assert property (
        stop_done && irq_source_en[5] |=> !int_n) else $error("halt int");
    a_int_holds: assert property (
        !int_n && !(status_rd && spi_active) |=> !int_n)
        else $error("int released early");
    a_flash_idle_port: assert property (
        flash_write_busy |=> !spi_active) else $error("port live in write");
    a_flash_done_int: assert property (
        $fell(flash_write_busy) && irq_source_en[7] |=> !int_n)
        else $error("write done int");
    a_auto_trim_quiet: assert property (
        trim_done && trim_auto && irq_source_en == 16'h0040 && int_n
        |=> int_n) else $error("auto trim flagged");
    a_cycle_flight_int: assert property (
        seq_mode == event_status_flags_pkg::SEQ_FLIGHT && per_cycle_irq
        && flight_cycle_done && irq_source_en[12] |=> !int_n)
        else $error("per-cycle flight int");
endmodule : event_status_flags_asserts

// ===== bench/host_model.sv
// Purpose: host side of the serial port, issues register reads
// Assumes: read strobe is taken on a rising edge with spi_active high
// Notes: strobe changes only at falling edges
`timescale 1ns/1ns
`include "event_status_flags_consts.svh"
module host_model (
    input wire logic clk,
    input wire logic spi_active,
    input wire logic status_rvalid,
    input wire logic [`ESF_WIDTH-1:0] status_rdata,
    output logic status_rd
);
    initial status_rd = 1'b0;
    // held until taken, at most 201 rising edges; no access while the port is idle
    task automatic read_word(output logic [`ESF_WIDTH-1:0] w,
                             output logic ok);
        int n;
        n = 0;
        @(negedge clk);
        status_rd = 1'b1;
        forever begin
            @(posedge clk);
            n++;
            if (spi_active === 1'b1 || n > 200) break;
        end
        @(negedge clk);
        status_rd = 1'b0;
        w = status_rdata;
        ok = (status_rvalid === 1'b1);
    endtask : read_word
endmodule : host_model

// ===== bench/event_status_flags_bench.sv
// Purpose: self-checking bench for the event flag register
// Assumes: inputs driven at falling edges, 50 ns clock
// Notes: events are pulsed one cycle, then read back through the host
`timescale 1ns/1ns
`include "event_status_flags_consts.svh"
module event_status_flags_bench;
    logic clk = 1'b0, rst_n = 1'b0, supply_good = 1'b0, per_cycle_irq = 1'b0;
    logic status_rd, status_rvalid, int_n, spi_active, tamper_pin = 1'b0;
    logic [15:0] irq_source_en = 16'hFFFF, status_rdata;
    logic [7:0] ev = 8'h00;
    logic [3:0] sq = 4'h0;
    logic reg_t = 1'b0, reg_o = 1'b0, reg_s = 1'b0, busy = 1'b0;
    logic trim_auto = 1'b0, rearm = 1'b0;
    event_status_flags_pkg::seq_mode_t seq_mode =
        event_status_flags_pkg::SEQ_IDLE;
    int n_mismatch = 0, total_checks = 0;
    int bits[8] = '{15, 14, 12, 11, 7, 6, 5, 3};
    event_status_flags i_event_status_flags (.clk(clk), .rst_n(rst_n),
        .status_rd(status_rd), .status_rdata(status_rdata),
        .status_rvalid(status_rvalid), .irq_source_en(irq_source_en),
        .int_n(int_n), .spi_active(spi_active), .supply_good(supply_good),
        .timeout_evt(ev[0]), .alarm_match_evt(ev[1]),
        .flight_cmd_done(ev[2]), .thermal_cmd_done(ev[3]),
        .seq_mode(seq_mode), .per_cycle_irq(per_cycle_irq),
        .flight_cycle_done(sq[0]), .thermal_cycle_done(sq[1]),
        .flight_last_done(sq[2]), .thermal_last_done(sq[3]),
        .regulator_timed_cmd(reg_t), .regulator_on_cmd(reg_o),
        .regulator_stable(reg_s), .flash_ready_evt(ev[4]),
        .flash_write_busy(busy), .trim_done(ev[5]), .trim_auto(trim_auto),
        .stop_done(ev[6]), .tamper_pin(tamper_pin), .tamper_rearm(rearm),
        .setup_done(ev[7]));
    host_model i_host_model (.clk(clk), .spi_active(spi_active),
        .status_rvalid(status_rvalid), .status_rdata(status_rdata),
        .status_rd(status_rd));
    initial forever #25 clk = ~clk;
    task automatic chk16(input string what, input logic [15:0] exp,
                         input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk16
    task automatic chk1(input string what, input logic exp, input logic got);
        chk16(what, {15'h0000, exp}, {15'h0000, got});
    endtask : chk1
    task automatic rd(input logic [15:0] exp);
        logic [15:0] w;
        logic ok;
        i_host_model.read_word(w, ok);
        chk1("status_rvalid", 1'b1, ok);
        chk16("status_rdata", exp, w);
    endtask : rd
    task automatic pulse(input logic [7:0] e, input logic [3:0] s);
        @(negedge clk);
        ev = e;
        sq = s;
        @(negedge clk);
        ev = 8'h00;
        sq = 4'h0;
    endtask : pulse
    task automatic t_power;
        repeat (4) @(negedge clk);
        chk1("spi_active", 1'b0, spi_active);
        supply_good = 1'b1;
        rd(16'h0004);
        rd(16'h0000);
        $display("test power done");
    endtask : t_power
    task automatic t_events;
        for (int k = 0; k < 8; k++) begin
            pulse(8'h01 << k, 4'h0);
            chk1("int_n", 1'b0, int_n);
            rd(16'h0001 << bits[k]);
            chk1("int_n", 1'b1, int_n);
        end
        rd(16'h0000);
        $display("test events done");
    endtask : t_events
    task automatic t_seq;
        logic fl, th;
        logic [15:0] e;
        for (int m = 0; m < 4; m++) begin
            for (int p = 0; p < 2; p++) begin
                seq_mode = event_status_flags_pkg::seq_mode_t'(m);
                per_cycle_irq = p[0];
                fl = (m == 1 || m == 2);
                th = (m == 1 || m == 3);
                pulse(8'h00, 4'hF);
                e = {3'b000, p[0] & fl, p[0] & th, 1'b0, fl, th, 8'h00};
                rd(e);
            end
        end
        seq_mode = event_status_flags_pkg::SEQ_IDLE;
        $display("test sequences done");
    endtask : t_seq
    task automatic t_misc;
        for (int c = 0; c < 2; c++) begin
            @(negedge clk);
            {reg_t, reg_o} = c[0] ? 2'b01 : 2'b10;
            reg_s = 1'b1;
            rd(16'h0400);
            {reg_t, reg_o, reg_s} = 3'b000;
        end
        // stable rising with no regulator command must stay silent
        @(negedge clk);
        reg_s = 1'b1;
        rd(16'h0000);
        reg_s = 1'b0;
        irq_source_en = 16'h0040;
        trim_auto = 1'b1;
        pulse(8'h20, 4'h0);
        chk1("int_n", 1'b1, int_n);
        rd(16'h0000);
        trim_auto = 1'b0;
        pulse(8'h20, 4'h0);
        chk1("int_n", 1'b0, int_n);
        rd(16'h0040);
        // halt source masked: flag posts, pin stays quiet
        pulse(8'h40, 4'h0);
        chk1("int_n", 1'b1, int_n);
        rd(16'h0020);
        irq_source_en = 16'hFFFF;
        busy = 1'b1;
        repeat (2) @(negedge clk);
        chk1("spi_active", 1'b0, spi_active);
        busy = 1'b0;
        repeat (2) @(negedge clk);
        chk1("int_n", 1'b0, int_n);
        rd(16'h0080);
        tamper_pin = 1'b1;
        repeat (6) @(negedge clk);
        rd(16'h0010);
        rd(16'h0000);
        rearm = 1'b1;
        @(negedge clk);
        rearm = 1'b0;
        rd(16'h0010);
        // let the synchroniser drain before rearming, or it refires
        tamper_pin = 1'b0;
        repeat (6) @(negedge clk);
        rearm = 1'b1;
        @(negedge clk);
        rearm = 1'b0;
        rd(16'h0000);
        $display("test misc done");
    endtask : t_misc
    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : close_out
    initial begin
        #(50 * 3000);
        n_mismatch++;
        close_out();
    end
    initial begin
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        t_power();
        t_events();
        t_seq();
        t_misc();
        close_out();
    end
endmodule : event_status_flags_bench
bind event_status_flags event_status_flags_asserts
    i_event_status_flags_asserts (
    .clk(clk), .rst_n(rst_n), .status_rd(status_rd),
    .status_rdata(status_rdata), .status_rvalid(status_rvalid),
    .irq_source_en(irq_source_en), .int_n(int_n), .spi_active(spi_active),
    .seq_mode(seq_mode), .per_cycle_irq(per_cycle_irq),
    .flight_cycle_done(flight_cycle_done),
    .flash_write_busy(flash_write_busy), .trim_done(trim_done),
    .trim_auto(trim_auto), .stop_done(stop_done));
